// [hw/asc_dev.sv]
// module: converter end, command decoder and channel data formatter
`timescale 1ns/10ps
module asc_dev #(
  // arbitrary identity value
  parameter logic [7:0] ID_VALUE = 8'h5A
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  asc_spi_if.dev spi,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  input wire logic conv_over,
  input wire logic [4:0] conv_tag,
  input wire logic supply_low,
  output logic [71:0] cfg_q,
  output logic pulse_convert_q,
  output logic reset_cmd_q,
  output logic data_ready_n_q
);
  // --------------------------------------------
  // pin synchronisation and edge detection
  // --------------------------------------------
  logic [3:0] pin_s;
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic supply_s;
  logic sclk_prev_q;
  logic rise;
  logic fall;

  asc_sync #(
    .W(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({spi.cs_n, spi.sclk, spi.din, supply_low}),
    .q(pin_s)
  );

  assign cs_s = pin_s[3];
  assign sclk_s = pin_s[2];
  assign din_s = pin_s[1];
  assign supply_s = pin_s[0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;

  // --------------------------------------------
  // interface timeout
  // --------------------------------------------
  logic [12:0] idle_q;
  logic [12:0] tmo_lim;
  logic tmo_hit;
  logic intf_rst;

  assign tmo_lim = cfg_q[asc_pkg::CFG0_TMO_SEL] ?
                   asc_pkg::TMO_SHORT : asc_pkg::TMO_LONG;
  assign tmo_hit = (idle_q == tmo_lim - 13'h1);
  assign intf_rst = cs_s | tmo_hit;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || rise || fall || cs_s) begin
      idle_q <= '0;
    end else if (idle_q != tmo_lim) begin
      idle_q <= idle_q + 13'h1;
    end
  end

  // --------------------------------------------
  // command decode
  // --------------------------------------------
  asc_pkg::asc_dev_state_t state_q;
  logic [4:0] rcnt_q;
  logic [6:0] sh_q;
  logic [3:0] addr_q;
  logic multi_q;
  logic [7:0] rx_byte;
  logic [2:0] op;
  logic byte_done;
  logic in_cmd;
  logic cmd_done;
  logic wr_byte;
  logic direct_hit;
  logic read_go;
  logic reset_go;
  logic rd_start;
  logic [4:0] dir_last;

  assign rx_byte = {sh_q, din_s};
  assign op = rx_byte[7:asc_pkg::OP_LSB];
  assign byte_done = rise && (rcnt_q[2:0] == asc_pkg::BYTE_LAST);
  assign in_cmd = (state_q == asc_pkg::DS_CMD);
  assign cmd_done = in_cmd && byte_done;
  assign wr_byte = (state_q == asc_pkg::DS_WRITE) && byte_done;
  assign direct_hit = in_cmd && rise && (rcnt_q == 5'h02) &&
                      ((rx_byte[2:0] == asc_pkg::OP_DIRECT_LO) ||
                       (rx_byte[2:0] == asc_pkg::OP_DIRECT_HI));
  assign read_go = cmd_done && (op == asc_pkg::OP_READ_CHAN);
  assign reset_go = cmd_done && (op == asc_pkg::OP_RESET);
  assign rd_start = direct_hit | read_go;
  assign dir_last = cfg_q[asc_pkg::CFG0_STAT_EN] ?
                    asc_pkg::FRAME_LAST_STAT : asc_pkg::FRAME_LAST_DATA;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || intf_rst) begin
      state_q <= asc_pkg::DS_CMD;
      rcnt_q <= '0;
      sh_q <= '0;
      addr_q <= '0;
      multi_q <= 1'b0;
    end else if (rise) begin
      sh_q <= rx_byte[6:0];
      rcnt_q <= rcnt_q + 5'h01;
      case (state_q)
        asc_pkg::DS_CMD: begin
          if (direct_hit) begin
            state_q <= asc_pkg::DS_DIRECT;
          end else if (byte_done) begin
            rcnt_q <= '0;
            case (op)
              asc_pkg::OP_WRITE: begin
                state_q <= asc_pkg::DS_WRITE;
                multi_q <= rx_byte[asc_pkg::MULTI_BIT];
                addr_q <= rx_byte[3:0];
              end
              asc_pkg::OP_READ_CHAN: begin
                state_q <= asc_pkg::DS_DREAD;
              end
              asc_pkg::OP_READ_REG: begin
                state_q <= asc_pkg::DS_LOCK;
              end
              default: begin
                state_q <= asc_pkg::DS_CMD;
              end
            endcase
          end
        end
        asc_pkg::DS_WRITE: begin
          if (byte_done) begin
            rcnt_q <= '0;
            if (!multi_q || addr_q >= asc_pkg::ID_ADDR) begin
              state_q <= asc_pkg::DS_CMD;
            end else begin
              addr_q <= addr_q + 4'h1;
            end
          end
        end
        asc_pkg::DS_DIRECT: begin
          if (rcnt_q == dir_last) begin
            state_q <= asc_pkg::DS_LOCK;
          end
        end
        asc_pkg::DS_DREAD: begin
          if (rcnt_q == asc_pkg::FRAME_LAST_STAT) begin
            state_q <= asc_pkg::DS_CMD;
            rcnt_q <= '0;
          end
        end
        asc_pkg::DS_LOCK: begin
          rcnt_q <= '0;
        end
        default: begin
          state_q <= asc_pkg::DS_CMD;
        end
      endcase
    end
  end

  // --------------------------------------------
  // configuration registers
  // --------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_go) begin
      cfg_q <= asc_pkg::CFG_RESET;
    end else if (wr_byte && addr_q < asc_pkg::ID_ADDR) begin
      cfg_q[{addr_q, 3'h0} +: 8] <= rx_byte;
    end
  end

  // --------------------------------------------
  // command pulses
  // --------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pulse_convert_q <= 1'b0;
      reset_cmd_q <= 1'b0;
    end else begin
      pulse_convert_q <= cmd_done && (op == asc_pkg::OP_PULSE);
      reset_cmd_q <= reset_go;
    end
  end

  // --------------------------------------------
  // channel data capture
  // --------------------------------------------
  logic [15:0] data_q;
  logic over_q;
  logic [4:0] tag_q;
  logic fresh_q;
  logic [7:0] status;
  logic [23:0] frame_direct;

  // reset command leaves the running conversion alone
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_q <= '0;
      over_q <= 1'b0;
      tag_q <= '0;
    end else if (conv_done) begin
      over_q <= conv_over;
      if (conv_over) begin
        data_q <= conv_data[15] ? asc_pkg::FS_NEG : asc_pkg::FS_POS;
      end else begin
        data_q <= conv_data;
      end
      if (cfg_q[asc_pkg::CFG0_SCAN_MODE]) begin
        tag_q <= '0;
      end else begin
        tag_q <= conv_tag;
      end
    end
  end

  // update wins over a read in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fresh_q <= 1'b0;
      data_ready_n_q <= 1'b1;
    end else if (conv_done) begin
      fresh_q <= 1'b1;
      data_ready_n_q <= 1'b0;
    end else if (rd_start) begin
      fresh_q <= 1'b0;
      data_ready_n_q <= 1'b1;
    end
  end

  assign status = {fresh_q, over_q, supply_s, tag_q};
  assign frame_direct = cfg_q[asc_pkg::CFG0_STAT_EN] ?
                        {status, data_q} : {data_q, 8'h00};

  // --------------------------------------------
  // serial output
  // --------------------------------------------
  logic [23:0] out_q;
  logic skip_q;
  logic dout_oe_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_q <= '0;
      skip_q <= 1'b0;
    end else if (read_go) begin
      out_q <= {status, data_q};
      skip_q <= 1'b1;
    end else if (fall) begin
      if (skip_q) begin
        skip_q <= 1'b0;
      end else begin
        out_q <= {out_q[22:0], 1'b0};
      end
    end else if (in_cmd && rcnt_q == 5'h00) begin
      out_q <= frame_direct;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dout_oe_q <= 1'b0;
    end else begin
      dout_oe_q <= ~cs_s;
    end
  end

  assign spi.dout = out_q[23];
  assign spi.dout_oe = dout_oe_q;

  // --------------------------------------------
  // parameter check
  // --------------------------------------------
  if (asc_pkg::NUM_CFG * 8 != 72) begin : g_chk
    $error("asc_dev: configuration width mismatch");
  end

  // identity register is read-only and kept outside the writable file
  logic [7:0] id_reg;
  assign id_reg = ID_VALUE;
endmodule : asc_dev

// [hw/asc_pkg.sv]
// package: constants and types of the adc serial command block
package asc_pkg;
  // --------------------------------------------
  // command byte
  // --------------------------------------------
  localparam int OP_LSB = 5;
  localparam int MULTI_BIT = 4;
  localparam logic [2:0] OP_DIRECT_LO = 3'h0;
  localparam logic [2:0] OP_READ_CHAN = 3'h1;
  localparam logic [2:0] OP_READ_REG = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_PULSE = 3'h4;
  localparam logic [2:0] OP_RESERVED = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;
  localparam logic [2:0] OP_DIRECT_HI = 3'h7;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // --------------------------------------------
  // configuration registers, reg 0 in low byte
  // --------------------------------------------
  localparam int NUM_CFG = 9;
  localparam logic [3:0] ID_ADDR = 4'h9;
  localparam logic [71:0] CFG_RESET = 72'h00_FF_00_FF_FF_00_00_83_0A;
  localparam int CFG0_TMO_SEL = 6;
  localparam int CFG0_SCAN_MODE = 5;
  localparam int CFG0_STAT_EN = 1;
  // --------------------------------------------
  // channel data format
  // --------------------------------------------
  localparam int ST_FRESH = 7;
  localparam int ST_OVER = 6;
  localparam int ST_SUPPLY = 5;
  localparam logic [15:0] FS_POS = 16'h7FFF;
  localparam logic [15:0] FS_NEG = 16'h8000;
  localparam logic [4:0] FRAME_LAST_STAT = 5'h17;
  localparam logic [4:0] FRAME_LAST_DATA = 5'h0F;
  localparam logic [4:0] TAG_PAIR0 = 5'h00;
  localparam logic [4:0] TAG_SINGLE0 = 5'h08;
  localparam logic [4:0] TAG_OFFSET = 5'h18;
  localparam logic [4:0] TAG_HOLE = 5'h19;
  localparam logic [4:0] TAG_SUPPLY = 5'h1A;
  localparam logic [4:0] TAG_TEMP = 5'h1B;
  localparam logic [4:0] TAG_GAIN = 5'h1C;
  localparam logic [4:0] TAG_REF = 5'h1D;
  // --------------------------------------------
  // interface timeout in master clocks
  // --------------------------------------------
  localparam logic [12:0] TMO_LONG = 13'h1000;
  localparam logic [12:0] TMO_SHORT = 13'h0100;
  // --------------------------------------------
  // host timing and register map
  // --------------------------------------------
  localparam int CLK_NS = 4;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_NS);
  localparam logic [7:0] HALF_MIN = 8'h06;
  localparam logic [7:0] HR_CTRL = 8'h00;
  localparam logic [7:0] HR_TX = 8'h04;
  localparam logic [7:0] HR_RX = 8'h08;
  localparam logic [7:0] HR_STAT = 8'h0C;
  localparam logic [7:0] HR_HALF = 8'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_LEN_LSB = 8;
  localparam logic [2:0] LEN_MAX = 3'h4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_READY = 2;
  // --------------------------------------------
  // state types
  // --------------------------------------------
  typedef enum logic [2:0] {
    DS_CMD = 3'h0,
    DS_WRITE = 3'h1,
    DS_DIRECT = 3'h2,
    DS_LOCK = 3'h6,
    DS_DREAD = 3'h4
  } asc_dev_state_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_LOW = 3'h1,
    HS_HIGH = 3'h3,
    HS_END = 3'h2,
    HS_GAP = 3'h6
  } asc_host_state_t;
endpackage : asc_pkg

// [hw/asc_spi_if.sv]
// interface: serial link between host controller and converter
`timescale 1ns/10ps
interface asc_spi_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  // pulled high while the converter leaves the line
  assign dout_line = dout_oe ? dout : 1'b1;
  modport dev (
    input cs_n,
    input sclk,
    input din,
    output dout,
    output dout_oe
  );
  modport host (
    output cs_n,
    output sclk,
    output din,
    input dout_line
  );
endinterface : asc_spi_if

// [hw/asc_sync.sv]
// module: two-flop synchroniser for signals from outside the domain
`timescale 1ns/10ps
module asc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

  if (W < 1) begin : g_chk
    $error("asc_sync: width must be positive");
  end
endmodule : asc_sync

// [hw/asc_host.sv]
// module: host end, apb-controlled serial command master
`timescale 1ns/10ps
module asc_host #(
  parameter logic [7:0] HALF_DEFAULT = 8'(asc_pkg::HALF_CYC)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_ready_n,
  asc_spi_if.host spi
);
  // --------------------------------------------
  // synchronisers
  // --------------------------------------------
  logic [1:0] in_s;

  asc_sync #(
    .W(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({spi.dout_line, data_ready_n}),
    .q(in_s)
  );

  // --------------------------------------------
  // apb registers
  // --------------------------------------------
  asc_pkg::asc_host_state_t hst_q;
  logic [2:0] len_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic [7:0] half_q;
  logic go_q;
  logic done_q;
  logic busy;
  logic wr_en;
  logic setup;
  logic [31:0] rd_val;
  logic hit;

  assign busy = go_q | (hst_q != asc_pkg::HS_IDLE);
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    rd_val = '0;
    hit = 1'b1;
    case (paddr)
      asc_pkg::HR_CTRL: rd_val[asc_pkg::CTRL_LEN_LSB +: 3] = len_q;
      asc_pkg::HR_TX: rd_val = tx_q;
      asc_pkg::HR_RX: rd_val = rx_q;
      asc_pkg::HR_STAT: begin
        rd_val[asc_pkg::STAT_BUSY] = busy;
        rd_val[asc_pkg::STAT_DONE] = done_q;
        rd_val[asc_pkg::STAT_READY] = ~in_s[0];
      end
      asc_pkg::HR_HALF: rd_val[7:0] = half_q;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      len_q <= 3'h1;
      tx_q <= '0;
      half_q <= HALF_DEFAULT;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wr_en && !busy) begin
        if (paddr == asc_pkg::HR_CTRL) begin
          go_q <= pwdata[asc_pkg::CTRL_GO];
          if (pwdata[asc_pkg::CTRL_LEN_LSB +: 3] == 3'h0) begin
            len_q <= 3'h1;
          end else if (pwdata[asc_pkg::CTRL_LEN_LSB +: 3] >
                       asc_pkg::LEN_MAX) begin
            len_q <= asc_pkg::LEN_MAX;
          end else begin
            len_q <= pwdata[asc_pkg::CTRL_LEN_LSB +: 3];
          end
        end
        if (paddr == asc_pkg::HR_TX) begin
          tx_q <= pwdata;
        end
        if (paddr == asc_pkg::HR_HALF) begin
          half_q <= (pwdata[7:0] < asc_pkg::HALF_MIN) ?
                    asc_pkg::HALF_MIN : pwdata[7:0];
        end
      end
    end
  end

  // --------------------------------------------
  // serial engine, one chip select frame a job
  // --------------------------------------------
  logic cs_n_q;
  logic sclk_q;
  logic mosi_q;
  logic [7:0] div_q;
  logic [5:0] bcnt_q;
  logic [31:0] sh_q;
  logic half_end;
  logic [5:0] last_bit;

  assign half_end = (div_q == half_q - 8'h01);
  assign last_bit = 6'({len_q, 3'h0}) - 6'h01;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hst_q <= asc_pkg::HS_IDLE;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      div_q <= '0;
      bcnt_q <= '0;
      sh_q <= '0;
      rx_q <= '0;
      done_q <= 1'b0;
    end else begin
      div_q <= half_end ? 8'h00 : div_q + 8'h01;
      case (hst_q)
        asc_pkg::HS_IDLE: begin
          div_q <= '0;
          if (go_q) begin
            cs_n_q <= 1'b0;
            sh_q <= tx_q;
            mosi_q <= tx_q[31];
            bcnt_q <= '0;
            done_q <= 1'b0;
            hst_q <= asc_pkg::HS_LOW;
          end
        end
        asc_pkg::HS_LOW: begin
          if (half_end) begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[30:0], in_s[1]};
            hst_q <= asc_pkg::HS_HIGH;
          end
        end
        asc_pkg::HS_HIGH: begin
          if (half_end) begin
            sclk_q <= 1'b0;
            if (bcnt_q == last_bit) begin
              hst_q <= asc_pkg::HS_END;
            end else begin
              bcnt_q <= bcnt_q + 6'h01;
              sh_q <= {sh_q[30:0], 1'b0};
              mosi_q <= sh_q[30];
              hst_q <= asc_pkg::HS_LOW;
            end
          end
        end
        asc_pkg::HS_END: begin
          if (half_end) begin
            cs_n_q <= 1'b1;
            hst_q <= asc_pkg::HS_GAP;
          end
        end
        asc_pkg::HS_GAP: begin
          if (half_end) begin
            done_q <= 1'b1;
            hst_q <= asc_pkg::HS_IDLE;
          end
        end
        default: begin
          hst_q <= asc_pkg::HS_IDLE;
        end
      endcase
    end
  end

  assign spi.cs_n = cs_n_q;
  assign spi.sclk = sclk_q;
  assign spi.din = mosi_q;

  if (HALF_DEFAULT < asc_pkg::HALF_MIN) begin : g_chk
    $error("asc_host: serial half period too short");
  end
endmodule : asc_host

// [test/asc_assertions.sv]
// checker: serial link framing and line rules between the two ends
`timescale 1ns/10ps
module asc_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic dout_line
);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_open;
    $fell(cs_n);
  endsequence
  sequence s_close;
    $rose(cs_n);
  endsequence
  a_oe_idle_off: assert property (cs_n [*4] |-> !dout_oe)
    else $error("serial output driven while deselected");
  a_oe_frame_on: assert property (s_open |-> ##[1:4] dout_oe)
    else $error("serial output not driven after select");
  a_line_pulled: assert property (!dout_oe |-> dout_line)
    else $error("released output line not high");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock active while deselected");
  a_frame_lead: assert property (s_open |-> !sclk [*6])
    else $error("serial clock too soon after select");
  a_sclk_high: assert property ($rose(sclk) |-> sclk [*6])
    else $error("serial clock high phase too short");
  a_din_hold: assert property ($rose(sclk) |-> $stable(din) [*6])
    else $error("input data moved around rising edge");
  a_cs_gap: assert property (s_close |-> cs_n [*6])
    else $error("deselect gap too short");
endmodule : asc_assertions

// [test/adc_serial_command_and_data_format_tb_top.sv]
// testbench: host and converter ends joined, driven over apb
`timescale 1ns/10ps
module adc_serial_command_and_data_format_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, data_ready_n, rst_cmd, pls_cmd;
  logic conv_done = 1'b0, conv_over = 1'b0, supply_low = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic [4:0] conv_tag = 5'h00;
  logic [71:0] cfg, exp_cfg;
  int num_errors = 0, tests_run = 0, n_rst = 0, n_pls = 0;
  asc_spi_if spi();
  asc_host #(.HALF_DEFAULT(8'h14)) i_asc_host (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_ready_n(data_ready_n), .spi(spi));
  asc_dev #(.ID_VALUE(8'h5A)) i_asc_dev (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .spi(spi), .conv_done(conv_done),
    .conv_data(conv_data), .conv_over(conv_over), .conv_tag(conv_tag),
    .supply_low(supply_low), .cfg_q(cfg), .pulse_convert_q(pls_cmd),
    .reset_cmd_q(rst_cmd), .data_ready_n_q(data_ready_n));
  asc_assertions i_asc_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cs_n(spi.cs_n), .sclk(spi.sclk), .din(spi.din), .dout(spi.dout),
    .dout_oe(spi.dout_oe), .dout_line(spi.dout_line));
  // ----------------------------------------
  // clock, pulse counters, tasks
  // ----------------------------------------
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rst_cmd === 1'b1) n_rst <= n_rst + 1;
    if (pls_cmd === 1'b1) n_pls <= n_pls + 1;
  end
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic job(input logic [31:0] tx, input int len,
                     output logic [31:0] rx);
    apb(1'b1, asc_pkg::HR_TX, tx, rx);
    apb(1'b1, asc_pkg::HR_CTRL, 32'(len) << 8 | 32'h1, rx);
    do begin
      apb(1'b0, asc_pkg::HR_STAT, 32'h0, rx);
    end while (rx[asc_pkg::STAT_DONE] !== 1'b1);
    apb(1'b0, asc_pkg::HR_RX, 32'h0, rx);
  endtask : job
  task automatic conv(input logic [15:0] d, input logic o,
                      input logic [4:0] t);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    conv_data <= d;
    conv_over <= o;
    conv_tag <= t;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : conv
  task automatic finish_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    exp_cfg = asc_pkg::CFG_RESET;
    @(posedge clk_sys);
    chk(cfg, exp_cfg);
    apb(1'b1, asc_pkg::HR_HALF, 32'h6, r);
    job(32'h61550000, 2, r);
    exp_cfg[15:8] = 8'h55;
    chk(cfg, exp_cfg);
    job(32'h77AABBCC, 4, r);
    exp_cfg[71:56] = 16'hBBAA;
    chk(cfg, exp_cfg);
    job(32'h62112200, 3, r);
    exp_cfg[23:16] = 8'h11;
    chk(cfg, exp_cfg);
    job(32'hA3EE0000, 2, r);
    chk(cfg, exp_cfg);
    job(32'h80000000, 1, r);
    chk(72'(n_pls), 72'h1);
    job(32'hC0000000, 1, r);
    chk(cfg, asc_pkg::CFG_RESET);
    chk(72'(n_rst), 72'h1);
    supply_low <= 1'b1;
    conv(16'h1234, 1'b0, 5'h05);
    chk(72'(data_ready_n), 72'h0);
    apb(1'b0, asc_pkg::HR_STAT, 32'h0, r);
    chk(72'(r[asc_pkg::STAT_READY]), 72'h1);
    job(32'h30000000, 4, r);
    chk(72'(r[23:0]), 72'hA51234);
    chk(72'(data_ready_n), 72'h1);
    job(32'h30000000, 4, r);
    chk(72'(r[23:0]), 72'h251234);
    supply_low <= 1'b0;
    conv(16'h1111, 1'b0, 5'h08);
    conv(16'h0123, 1'b1, 5'h1D);
    job(32'h30000000, 4, r);
    chk(72'(r[23:0]), 72'hDD7FFF);
    conv(16'hF000, 1'b1, 5'h18);
    job(32'h00000000, 3, r);
    chk(72'(r[23:0]), 72'hD88000);
    job(32'h61330000, 2, r);
    chk(72'(cfg[15:8]), 72'h33);
    job(32'h60200000, 2, r);
    conv(16'h4321, 1'b0, 5'h07);
    job(32'h30000000, 4, r);
    chk(72'(r[23:0]), 72'h804321);
    finish_test();
  end
endmodule : adc_serial_command_and_data_format_tb_top
